// File: pkg/sps_pkg.sv
package sps_pkg;
	// device register addresses on the parallel port
	localparam logic [5:0] ADDR_PAGE = 6'h00;
	localparam logic [5:0] ADDR_CMD = 6'h01;
	localparam logic [5:0] ADDR_CTRL = 6'h09;
	localparam logic [5:0] ADDR_TXCTRL = 6'h11;
	localparam logic [5:0] ADDR_CFG_LO = 6'h10;
	localparam logic [5:0] ADDR_CFG_HI = 6'h2F;
	// control register fields
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int CTRL_STANDBY_BIT = 1;
	localparam int CTRL_RXAUTO_BIT = 2;
	// transmitter control fields
	localparam int TX_ONE_EN_BIT = 0;
	localparam int TX_TWO_EN_BIT = 1;
	localparam int TX_TWO_INV_BIT = 3;
	// command codes and page values
	localparam logic [5:0] CMD_STARTUP = 6'h3F;
	localparam logic [5:0] CMD_IDLE = 6'h00;
	localparam logic [7:0] PAGE_DETECT = 8'h80;
	localparam logic [7:0] PAGE_LINEAR = 8'h00;
	localparam logic [7:0] PAGE_RESET = 8'h80;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// phase lengths in clock cycles (standby exit in oscillator ticks), configuration byte count
	localparam int RESET_CYC = 512;
	localparam int INIT_CYC = 128;
	localparam int SLEEP_EXIT_CYC = 512;
	localparam int STANDBY_EXIT_TICKS = 4;
	localparam int CFG_BYTES = 32;
	// host timing: power-down pin pulse
	localparam int CLK_HZ = 25000000;
	localparam int PD_MIN_US = 100;
	localparam int PD_CYC = (PD_MIN_US * (CLK_HZ / 1000000));
	// host apb register offsets
	localparam logic [7:0] APB_CTRL = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_ACCESS = 8'h08;
	// device start-up phases
	typedef enum logic [1:0] {PH_HPD, PH_RESET, PH_INIT, PH_RUN} sps_phase_t;
	// host sequencer states
	typedef enum logic [2:0] {HS_IDLE, HS_PD, HS_POLL, HS_PAGE80, HS_CHECK, HS_PAGE00,
		HS_USER} sps_hstate_t;
endpackage : sps_pkg

// File: pkg/sps_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sps_link_if;
	logic pd_pin; // power-down reset pin, high = hard power-down
	logic req; // host access request, held until ack
	logic we; // 1 = write
	logic [5:0] addr; // register address
	logic [7:0] wdata; // write data
	logic ack; // device answer, one cycle
	logic [7:0] rdata; // read data, valid with ack
	modport dev (input pd_pin, input req, input we, input addr, input wdata,
		output ack, output rdata);
	modport host (output pd_pin, output req, output we, output addr, output wdata,
		input ack, input rdata);
endinterface : sps_link_if
`default_nettype wire

// File: hw/sps_device.sv
// The implementer's own choices: the parallel link port and the address map.
`timescale 1ns/1ns
`default_nettype none
module sps_device
	import sps_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_CE,
	input wire logic I_POR,
	input wire logic I_OSC_STABLE,
	input wire logic I_OSC_TICK,
	input wire logic I_RX_BUSY,
	input wire logic [7:0] I_NV_DATA,
	sps_link_if.dev LINK,
	output logic [5:0] O_NV_ADDR,
	output logic O_OSC_RUN,
	output logic O_OSC_IN_PULLDOWN,
	output logic O_OSC_OUT_HIGH,
	output logic O_SINKS_ON,
	output logic O_DIG_CLK_ON,
	output logic O_INPUT_ISOLATE,
	output logic O_RX_POWER,
	output logic O_TX1,
	output logic O_TX2,
	output logic [5:0] O_CMD,
	output logic O_IF_READY,
	output logic O_LINEAR
);
	// three-stage pin synchronisers: por, osc stable, osc tick
	logic [2:0] pin_in;
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] s3_reg;
	logic [2:0] flt_reg; // value accepted once stages two and three agree
	logic tick_prev_reg;
	assign pin_in = {I_OSC_TICK, I_OSC_STABLE, I_POR};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			// first stage feeds only the second stage
			always_ff @(posedge I_CLK)
			begin
				if (I_SYS_RST)
				begin
					s1_reg[gi] <= 1'b0;
					s2_reg[gi] <= 1'b0;
					s3_reg[gi] <= 1'b0;
					flt_reg[gi] <= 1'b0;
				end
				else if (I_CE)
				begin
					s1_reg[gi] <= pin_in[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi])
						flt_reg[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate

	// state
	sps_phase_t phase_reg;
	logic [9:0] cnt_reg; // phase cycle counter
	logic [7:0] cfg_mem [0:CFG_BYTES-1]; // copied configuration bytes
	logic [5:0] cmd_reg;
	logic [7:0] page_reg;
	logic sleep_reg; // soft sleep bit as read back
	logic sleep_exit_reg; // exit countdown running
	logic [9:0] sleep_cnt_reg;
	logic standby_reg;
	logic standby_exit_reg;
	logic [2:0] stby_cnt_reg;
	logic rx_auto_reg;
	logic if_init_reg; // detection access seen
	logic linear_reg;
	logic ack_reg;
	logic [7:0] rdata_reg;
	logic tx1_reg;
	logic tx2_reg;

	// decode
	wire hpd_req = LINK.pd_pin | flt_reg[0];
	wire in_hpd = (phase_reg == PH_HPD);
	wire osc_tick = flt_reg[2] & ~tick_prev_reg;
	// inputs are isolated in hard power-down, so no access is taken
	wire acc = LINK.req & ~ack_reg & ~in_hpd & ~hpd_req;
	wire run = (phase_reg == PH_RUN);
	wire wr = acc & LINK.we & run; // start-up ignores writes
	wire wr_ctrl = wr & (LINK.addr == ADDR_CTRL);
	wire wr_page = wr & (LINK.addr == ADDR_PAGE);
	wire wr_cmd = wr & (LINK.addr == ADDR_CMD);
	wire in_cfg = (LINK.addr >= ADDR_CFG_LO) && (LINK.addr <= ADDR_CFG_HI);
	wire wr_cfg = wr & in_cfg;
	wire [4:0] cfg_idx = 5'(LINK.addr - ADDR_CFG_LO);
	wire [4:0] tx_idx = 5'(ADDR_TXCTRL - ADDR_CFG_LO);
	wire [7:0] txc = cfg_mem[tx_idx];
	wire [7:0] ctrl_rd = {5'h00, rx_auto_reg, standby_reg, sleep_reg};
	wire [7:0] rd_mux = (LINK.addr == ADDR_PAGE) ? page_reg :
		(LINK.addr == ADDR_CMD) ? {2'b00, cmd_reg} :
		(LINK.addr == ADDR_CTRL) ? ctrl_rd :
		in_cfg ? cfg_mem[cfg_idx] : 8'h00;
	wire init_copy = (phase_reg == PH_INIT) && (cnt_reg < 10'(CFG_BYTES));
	wire [4:0] copy_idx = cnt_reg[4:0];
	// last init cycle with no power-down pending: run starts at the next edge
	wire init_last = (phase_reg == PH_INIT) && (cnt_reg == 10'(INIT_CYC - 1)) && ~hpd_req;

	// phase sequencer: hard power-down, reset, init, run
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			phase_reg <= PH_HPD;
			cnt_reg <= 10'h000;
		end
		else if (I_CE)
		begin
			if (hpd_req)
			begin
				phase_reg <= PH_HPD;
				cnt_reg <= 10'h000;
			end
			else
			begin
				case (phase_reg)
					PH_HPD:
						if (flt_reg[1])
							phase_reg <= PH_RESET;
					PH_RESET:
						if (cnt_reg == 10'(RESET_CYC - 1))
						begin
							phase_reg <= PH_INIT;
							cnt_reg <= 10'h000;
						end
						else
							cnt_reg <= cnt_reg + 10'h001;
					PH_INIT:
						if (cnt_reg == 10'(INIT_CYC - 1))
						begin
							phase_reg <= PH_RUN;
							cnt_reg <= 10'h000;
						end
						else
							cnt_reg <= cnt_reg + 10'h001;
					PH_RUN:
						cnt_reg <= 10'h000;
					default:
						phase_reg <= PH_HPD;
				endcase
			end
		end
	end

	// configuration bytes: nonvolatile copy in init, host writes in run
	always_ff @(posedge I_CLK)
	begin
		if (I_CE && init_copy)
			cfg_mem[copy_idx] <= I_NV_DATA;
		else if (I_CE && wr_cfg)
			cfg_mem[cfg_idx] <= LINK.wdata;
	end

	// command and interface detection
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			cmd_reg <= CMD_STARTUP;
			page_reg <= PAGE_RESET;
			if_init_reg <= 1'b0;
			linear_reg <= 1'b0;
		end
		else if (I_CE)
		begin
			if (!run)
			begin
				// idle is loaded on the edge that ends init, so it shows from the first run cycle
				cmd_reg <= init_last ? CMD_IDLE : CMD_STARTUP;
				page_reg <= PAGE_RESET;
				if_init_reg <= 1'b0;
				linear_reg <= 1'b0;
			end
			else
			begin
				if (wr_cmd)
					cmd_reg <= LINK.wdata[5:0];
				if (wr_page)
				begin
					page_reg <= LINK.wdata;
					if (LINK.wdata == PAGE_DETECT)
						if_init_reg <= 1'b1;
					else if (LINK.wdata == PAGE_LINEAR && if_init_reg)
						linear_reg <= 1'b1;
				end
			end
		end
	end

	// idle command appears the cycle run is entered
	// (cmd_reg holds 3Fh through init; see previous process)

	// power modes: soft sleep and standby with delayed exit
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			sleep_reg <= 1'b0;
			sleep_exit_reg <= 1'b0;
			sleep_cnt_reg <= 10'h000;
			standby_reg <= 1'b0;
			standby_exit_reg <= 1'b0;
			stby_cnt_reg <= 3'h0;
			rx_auto_reg <= 1'b0;
			tick_prev_reg <= 1'b0;
		end
		else if (I_CE)
		begin
			tick_prev_reg <= flt_reg[2];
			if (!run)
			begin
				// presets in reset phase, cleared by hard power-down
				sleep_reg <= 1'b0;
				sleep_exit_reg <= 1'b0;
				standby_reg <= 1'b0;
				standby_exit_reg <= 1'b0;
				rx_auto_reg <= CTRL_RESET[CTRL_RXAUTO_BIT];
			end
			else
			begin
				if (wr_ctrl)
					rx_auto_reg <= LINK.wdata[CTRL_RXAUTO_BIT];
				// a new set wins over a pending exit
				if (wr_ctrl && LINK.wdata[CTRL_SLEEP_BIT])
				begin
					sleep_reg <= 1'b1;
					sleep_exit_reg <= 1'b0;
				end
				else if (wr_ctrl && sleep_reg && !sleep_exit_reg)
				begin
					sleep_exit_reg <= 1'b1;
					sleep_cnt_reg <= 10'h000;
				end
				else if (sleep_exit_reg)
				begin
					if (sleep_cnt_reg == 10'(SLEEP_EXIT_CYC - 1))
					begin
						sleep_reg <= 1'b0;
						sleep_exit_reg <= 1'b0;
					end
					else
						sleep_cnt_reg <= sleep_cnt_reg + 10'h001;
				end
				if (wr_ctrl && LINK.wdata[CTRL_STANDBY_BIT])
				begin
					standby_reg <= 1'b1;
					standby_exit_reg <= 1'b0;
				end
				else if (wr_ctrl && standby_reg && !standby_exit_reg)
				begin
					standby_exit_reg <= 1'b1;
					stby_cnt_reg <= 3'h0;
				end
				else if (standby_exit_reg && osc_tick)
				begin
					if (stby_cnt_reg == 3'(STANDBY_EXIT_TICKS - 1))
					begin
						standby_reg <= 1'b0;
						standby_exit_reg <= 1'b0;
					end
					else
						stby_cnt_reg <= stby_cnt_reg + 3'h1;
				end
			end
		end
	end

	// access answer and frozen pin levels
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
			tx1_reg <= 1'b0;
			tx2_reg <= 1'b0;
		end
		else if (I_CE)
		begin
			ack_reg <= acc;
			if (acc)
				rdata_reg <= rd_mux;
			// transmitter levels are latched outside hard power-down only
			if (!in_hpd)
			begin
				tx1_reg <= txc[TX_ONE_EN_BIT];
				tx2_reg <= txc[TX_TWO_EN_BIT] & ~txc[TX_TWO_INV_BIT];
			end
		end
	end

	assign LINK.ack = ack_reg;
	assign LINK.rdata = rdata_reg;
	assign O_NV_ADDR = 6'(ADDR_CFG_LO + 6'(copy_idx));
	assign O_OSC_RUN = ~in_hpd & ~sleep_reg;
	assign O_OSC_IN_PULLDOWN = in_hpd;
	assign O_OSC_OUT_HIGH = in_hpd;
	assign O_SINKS_ON = ~in_hpd & ~sleep_reg & ~standby_reg;
	assign O_DIG_CLK_ON = ~in_hpd & ~standby_reg;
	assign O_INPUT_ISOLATE = in_hpd;
	assign O_RX_POWER = ~in_hpd & ~sleep_reg & (~rx_auto_reg | I_RX_BUSY);
	assign O_TX1 = tx1_reg;
	assign O_TX2 = tx2_reg;
	assign O_CMD = cmd_reg;
	assign O_IF_READY = if_init_reg;
	assign O_LINEAR = linear_reg;
endmodule : sps_device
`default_nettype wire

// File: hw/sps_host.sv
`timescale 1ns/1ns
`default_nettype none
module sps_host
	import sps_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_CE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	sps_link_if.host LINK
);
	sps_hstate_t st_reg;
	logic [11:0] pd_cnt_reg; // pin pulse length counter
	logic req_reg;
	logic we_reg;
	logic [5:0] addr_reg;
	logic [7:0] wdata_reg;
	logic pd_reg;
	logic done_reg; // bring-up finished
	logic fail_reg; // detection read was not idle
	logic [7:0] last_rd_reg;
	logic [15:0] user_reg; // queued user access: we, addr, data

	// apb decode: zero wait, writes only while idle
	wire apb_wr = I_PSEL & I_PENABLE & I_PWRITE;
	wire idle = (st_reg == HS_IDLE);
	wire go_ctrl = apb_wr & (I_PADDR == APB_CTRL) & idle;
	wire go_acc = apb_wr & (I_PADDR == APB_ACCESS) & idle;
	wire got = req_reg & LINK.ack; // answer for the pending access
	wire [31:0] status = {16'h0000, last_rd_reg, 5'h00, fail_reg, done_reg, ~idle};
	assign O_PRDATA = (I_PSEL && I_PADDR == APB_STATUS) ? status : 32'h0000_0000;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = 1'b0;

	// sequencer: pin pulse, poll idle, detection handshake, user access
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			st_reg <= HS_IDLE;
			pd_cnt_reg <= 12'h000;
			req_reg <= 1'b0;
			we_reg <= 1'b0;
			addr_reg <= 6'h00;
			wdata_reg <= 8'h00;
			pd_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			last_rd_reg <= 8'h00;
			user_reg <= 16'h0000;
		end
		else if (I_CE)
		begin
			if (got)
			begin
				req_reg <= 1'b0;
				last_rd_reg <= LINK.rdata;
			end
			case (st_reg)
				HS_IDLE:
					if (go_ctrl && I_PWDATA[0])
					begin
						st_reg <= HS_PD;
						pd_reg <= 1'b1;
						pd_cnt_reg <= 12'h000;
						done_reg <= 1'b0;
						fail_reg <= 1'b0;
					end
					else if (go_ctrl && I_PWDATA[1])
					begin
						st_reg <= HS_POLL;
						done_reg <= 1'b0;
						fail_reg <= 1'b0;
					end
					else if (go_acc)
					begin
						st_reg <= HS_USER;
						user_reg <= {I_PWDATA[16], 1'b0, I_PWDATA[5:0], I_PWDATA[15:8]};
					end
				HS_PD:
					if (pd_cnt_reg == 12'(PD_CYC - 1))
					begin
						pd_reg <= 1'b0;
						st_reg <= HS_POLL;
					end
					else
						pd_cnt_reg <= pd_cnt_reg + 12'h001;
				HS_POLL:
					// reread the command until the low six bits are idle
					if (!req_reg)
					begin
						req_reg <= 1'b1;
						we_reg <= 1'b0;
						addr_reg <= ADDR_CMD;
					end
					else if (got && LINK.rdata[5:0] == CMD_IDLE)
						st_reg <= HS_PAGE80;
				HS_PAGE80:
					if (!req_reg)
					begin
						req_reg <= 1'b1;
						we_reg <= 1'b1;
						addr_reg <= ADDR_PAGE;
						wdata_reg <= PAGE_DETECT;
					end
					else if (got)
						st_reg <= HS_CHECK;
				HS_CHECK:
					if (!req_reg)
					begin
						req_reg <= 1'b1;
						we_reg <= 1'b0;
						addr_reg <= ADDR_CMD;
					end
					else if (got)
					begin
						fail_reg <= (LINK.rdata != 8'h00);
						st_reg <= HS_PAGE00;
					end
				HS_PAGE00:
					if (!req_reg)
					begin
						req_reg <= 1'b1;
						we_reg <= 1'b1;
						addr_reg <= ADDR_PAGE;
						wdata_reg <= PAGE_LINEAR;
					end
					else if (got)
					begin
						done_reg <= 1'b1;
						st_reg <= HS_IDLE;
					end
				HS_USER:
					if (!req_reg)
					begin
						req_reg <= 1'b1;
						we_reg <= user_reg[15];
						addr_reg <= user_reg[13:8];
						wdata_reg <= user_reg[7:0];
					end
					else if (got)
						st_reg <= HS_IDLE;
				default:
					st_reg <= HS_IDLE;
			endcase
		end
	end

	assign LINK.pd_pin = pd_reg;
	assign LINK.req = req_reg;
	assign LINK.we = we_reg;
	assign LINK.addr = addr_reg;
	assign LINK.wdata = wdata_reg;
endmodule : sps_host
`default_nettype wire

// File: testbench/sps_link_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sps_link_monitor
	import sps_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic pd_pin,
	input wire logic req,
	input wire logic we,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic [7:0] rdata
);
	// pin-high cycle count, saturates so a stuck pin cannot wrap
	logic [12:0] pd_cnt_reg;
	// count while the power-down pin stays high
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST || !pd_pin)
			pd_cnt_reg <= 13'h0000;
		else if (pd_cnt_reg != 13'h1FFF)
			pd_cnt_reg <= pd_cnt_reg + 13'h0001;
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("ack held past one cycle");
	a_ack_has_cause: assert property ($rose(ack) |-> $past(req) && !$past(pd_pin))
		else $error("ack without a request");
	a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
		&& $stable(wdata)) else $error("request changed before ack");
	a_req_drops: assert property (ack |=> !req)
		else $error("request kept after ack");
	a_no_ack_pd: assert property (pd_pin |=> !ack)
		else $error("ack during hard power-down");
	a_pd_length: assert property ($fell(pd_pin) |-> pd_cnt_reg >= PD_CYC)
		else $error("power-down pulse too short");
	a_rdata_hold: assert property (!ack |-> $stable(rdata))
		else $error("read data moved without ack");
	a_page_value: assert property (req && we && addr == ADDR_PAGE |->
		wdata == PAGE_DETECT || wdata == PAGE_LINEAR) else $error("bad page value");
endmodule : sps_link_monitor
`default_nettype wire

// File: testbench/startup_power_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t mismatch", $time); end end
module startup_power_sequencer_bench;
	import sps_pkg::*;
	// bench-driven inputs, all valued at time zero
	logic clk = 1'b0, rst = 1'b1, por = 1'b1, stab = 1'b0, tick = 1'b0, busy = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, mark = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic pready, pslverr, osc_run, pull, ohigh, sinks, dclk, iso, rxp, tx1, tx2, ifr, lin;
	logic [5:0] nv_addr, cmd;
	logic [7:0] nv_tab [32]; // nonvolatile image, random
	logic [7:0] nv_data;
	logic [7:0] txv [4] = '{8'h03, 8'h0A, 8'h08, 8'h01}; // tx enable/invert cases
	logic [31:0] q_exp [$], q_msk [$]; // noted read results
	int bad_count = 0, checks = 0, n;
	sps_link_if link ();
	// memory answers in the same cycle as the address
	// image byte i lives at device address 10h + i
	assign nv_data = nv_tab[5'(nv_addr - ADDR_CFG_LO)];
	sps_host sps_host_i (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(link.host));
	sps_device sps_device_i (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_POR(por),
		.I_OSC_STABLE(stab), .I_OSC_TICK(tick), .I_RX_BUSY(busy), .I_NV_DATA(nv_data),
		.LINK(link.dev), .O_NV_ADDR(nv_addr), .O_OSC_RUN(osc_run), .O_OSC_IN_PULLDOWN(pull),
		.O_OSC_OUT_HIGH(ohigh), .O_SINKS_ON(sinks), .O_DIG_CLK_ON(dclk), .O_INPUT_ISOLATE(iso),
		.O_RX_POWER(rxp), .O_TX1(tx1), .O_TX2(tx2), .O_CMD(cmd), .O_IF_READY(ifr),
		.O_LINEAR(lin));
	sps_link_monitor sps_link_monitor_i (.I_CLK(clk), .I_SYS_RST(rst), .pd_pin(link.pd_pin),
		.req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
		.rdata(link.rdata));
	// 25 MHz clock
	initial
	begin
		forever #20 clk = ~clk;
	end
	// one apb transfer; mark flags reads whose result was noted
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
		output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		mark <= c;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
		mark <= 1'b0;
	endtask : apb
	// note the expected word, then read it
	task expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] r;
		q_msk.push_back(m);
		q_exp.push_back(v & m);
		apb(1'b0, a, 32'h00000000, 1'b1, r);
	endtask : expect_rd
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, 1'b0, r);
	endtask : wr
	// poll busy; the 4000-poll limit covers a sequencer that never settles
	task wait_idle;
		logic [31:0] r;
		int k;
		k = 0;
		do
		begin
			apb(1'b0, APB_STATUS, 32'h00000000, 1'b0, r);
			k++;
		end
		while (r[0] !== 1'b0 && k < 4000);
	endtask : wait_idle
	task dev_wr(input logic [5:0] a, input logic [7:0] d);
		wr(APB_ACCESS, {15'h0000, 1'b1, d, 2'b00, a});
		wait_idle();
	endtask : dev_wr
	task dev_rd(input logic [5:0] a, input logic [7:0] v);
		wr(APB_ACCESS, {24'h000000, 2'b00, a});
		wait_idle();
		expect_rd(APB_STATUS, 32'h0000FF00, {16'h0000, v, 8'h00});
	endtask : dev_rd
	// oscillator input edges, slow against the clock
	task ticks(input int t);
		repeat (t)
		begin
			@(posedge clk);
			tick <= 1'b1;
			repeat (4) @(posedge clk);
			tick <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask : ticks
	task report_and_stop;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	// compare each noted read as it completes
	always @(posedge clk)
	begin
		if (mark && psel && pen && pready === 1'b1 && q_exp.size() > 0)
		begin
			`CHK(prdata & q_msk[0], q_exp[0])
			void'(q_exp.pop_front());
			void'(q_msk.pop_front());
		end
	end
	// hang guard, a few times the expected run
	initial
	begin
		repeat (100000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(65309));
		for (int i = 0; i < 32; i++)
			nv_tab[i] = 8'($urandom());
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		stab <= 1'b1;
		repeat (20) @(posedge clk);
		// power-on reset alone keeps the device down
		`CHK(iso, 1'b1)
		`CHK(pull, 1'b1)
		`CHK(ohigh, 1'b1)
		`CHK(osc_run | sinks, 1'b0)
		`CHK(cmd, CMD_STARTUP)
		por <= 1'b0;
		n = 0;
		while (iso !== 1'b0 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (cmd !== CMD_IDLE && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		`CHK(n >= RESET_CYC + INIT_CYC - 2 && n <= RESET_CYC + INIT_CYC + 2, 1'b1)
		wr(APB_CTRL, 32'h00000002);
		wait_idle();
		expect_rd(APB_STATUS, 32'h00000006, 32'h00000002);
		`CHK(ifr, 1'b1)
		`CHK(lin, 1'b1)
		for (int i = 0; i < 32; i++)
			dev_rd(ADDR_CFG_LO + 6'(i), nv_tab[i]);
		// soft sleep: stays set for the exit count
		dev_wr(ADDR_CTRL, 8'h01);
		`CHK(osc_run | sinks, 1'b0)
		dev_wr(ADDR_CTRL, 8'h00);
		dev_rd(ADDR_CTRL, 8'h01);
		repeat (SLEEP_EXIT_CYC) @(posedge clk);
		dev_rd(ADDR_CTRL, 8'h00);
		`CHK(osc_run, 1'b1)
		// standby: oscillator stays, exit waits for ticks
		dev_wr(ADDR_CTRL, 8'h02);
		`CHK({osc_run, dclk, sinks}, 3'b100)
		dev_wr(ADDR_CTRL, 8'h00);
		ticks(STANDBY_EXIT_TICKS - 1);
		`CHK(dclk, 1'b0)
		ticks(1);
		repeat (8) @(posedge clk);
		`CHK(dclk, 1'b1)
		for (int k = 0; k < 2; k++)
		begin
			dev_wr(ADDR_CTRL, (k == 1) ? 8'h04 : 8'h00);
			repeat (6)
			begin
				busy <= 1'($urandom());
				@(posedge clk);
				@(posedge clk);
				`CHK(rxp, (k == 0) | busy)
			end
		end
		// hard power-down over sleep and standby, then full restart
		for (int k = 0; k < 4; k++)
		begin
			dev_wr(ADDR_TXCTRL, txv[k]);
			dev_wr(ADDR_CTRL, 8'h03);
			wr(APB_CTRL, 32'h00000001);
			n = 0;
			while (iso !== 1'b1 && n < 100)
			begin
				@(posedge clk);
				n++;
			end
			repeat (50) @(posedge clk);
			`CHK(tx1, txv[k][0])
			`CHK(tx2, txv[k][1] & !txv[k][3])
			`CHK({iso, pull, ohigh, sinks}, 4'b1110)
			wait_idle();
			expect_rd(APB_STATUS, 32'h00000006, 32'h00000002);
			`CHK({osc_run, dclk, lin}, 3'b111)
			dev_rd(ADDR_TXCTRL, nv_tab[1]);
		end
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule : startup_power_sequencer_bench
`default_nettype wire
